// *** hw/tbm_pkg.sv ***
// Package of constants and types for the trigger and burst mode control block
package tbm_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W       = 8;
  localparam int          DATA_W       = 32;
  localparam logic [7:0]  CTRL_OFS     = 8'h00;
  localparam logic [7:0]  TRIG_OFS     = 8'h04;
  localparam logic [7:0]  SHIFT_OFS    = 8'h08;
  localparam logic [7:0]  STATUS_OFS   = 8'h0C;
  localparam logic [7:0]  PRESET_OFS   = 8'h10;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int          CTRL_W       = 9;
  localparam int          CNT_W        = 16;
  localparam int          SERIAL_BIT   = 0;
  localparam int          MAN_TRIG_BIT = 0;
  localparam int          ST_RUN_BIT   = 0;
  localparam int          ST_INV_BIT   = 1;
  localparam int          ST_BURST_BIT = 2;
  localparam int          ST_CNT_LSB   = 16;

  // Arb clock source codes
  localparam logic [1:0]  SRC_SQUARE   = 2'h0;
  localparam logic [1:0]  SRC_REF      = 2'h1;
  localparam logic [1:0]  SRC_EXT      = 2'h2;
  localparam logic [1:0]  SRC_LOCAL    = 2'h3;

  // Control register, bit 0 is mode_select_a
  typedef struct packed {
    logic       count_load_enable;
    logic [1:0] arb_clk_source_b;
    logic [1:0] arb_clk_source_a;
    logic       trigger_source_sel;
    logic       gate_select;
    logic       mode_select_b;
    logic       mode_select_a;
  } tbm_ctrl_t;

  localparam tbm_ctrl_t CTRL_RESET = 9'h000;

  // Decoded operating mode, one-hot
  typedef enum logic [4:0] {
    MODE_IDLE    = 5'h01,
    MODE_CONT    = 5'h02,
    MODE_TRIG    = 5'h04,
    MODE_EXTGATE = 5'h08,
    MODE_BURST   = 5'h10
  } tbm_mode_t;

endpackage

// *** hw/tbm_burst_counter.sv ***
// Serially preset down counter that measures burst length
module tbm_burst_counter #(
  parameter int CNT_W = tbm_pkg::CNT_W
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Serial preset
  input  wire logic             count_shift_clock,
  input  wire logic             count_serial_in,
  // Counting
  input  wire logic             load,
  input  wire logic             count_decrement_clock,
  // State
  output logic [CNT_W-1:0]      preset,
  output logic [CNT_W-1:0]      count,
  output logic                  burst_active
);

  logic [CNT_W-1:0] next_preset;
  logic [CNT_W-1:0] next_count;

  // Shift, load and decrement; load wins so a new burst starts full
  always_comb begin
    next_preset = preset;
    next_count  = count;
    if (count_shift_clock) begin
      next_preset = {preset[CNT_W-2:0], count_serial_in};
    end
    if (load) begin
      next_count = preset;
    end else if (count_decrement_clock && count != '0) begin
      next_count = count - {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      preset <= '0;
      count  <= '0;
    end else begin
      preset <= next_preset;
      count  <= next_count;
    end
  end

  // Burst line drops when the count reaches zero
  assign burst_active = (count != '0);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_count_down_step: assert property (
    count_decrement_clock && !load && count != '0 |=> count == $past(count) - 1'b1)
    else $error("burst count did not step down by one");

  a_serial_shift_in: assert property (
    count_shift_clock |=> preset[0] == $past(count_serial_in)
                          && preset[CNT_W-1:1] == $past(preset[CNT_W-2:0]))
    else $error("serial preset bit not shifted in");

  a_preset_hold: assert property (
    !count_shift_clock |=> preset == $past(preset))
    else $error("preset changed without a shift clock");

endmodule

// *** hw/tbm_mode_ctrl.sv ***
// Trigger, gate and burst mode control with run flop and arb clock select
//
// Our own choices: the register offsets and register access over APB.
module tbm_mode_ctrl #(
  parameter int CNT_W = tbm_pkg::CNT_W
) (
  // Clock and reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // APB slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [tbm_pkg::ADDR_W-1:0] paddr,
  input  wire logic [tbm_pkg::DATA_W-1:0] pwdata,
  output logic      [tbm_pkg::DATA_W-1:0] prdata,
  output logic                            pready,
  output logic                            pslverr,
  // Waveform and trigger inputs
  input  wire logic                       gen_square_wave,
  input  wire logic                       reference_a,
  input  wire logic                       external_freq_in,
  input  wire logic                       local_clock,
  input  wire logic                       manual_trigger,
  // Generator control and arb clocks
  output logic                            run,
  output logic                            flop_inverted_out,
  output logic                            arb_clock_a,
  output logic                            arb_clock_b
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  tbm_pkg::tbm_ctrl_t            ctrl;
  tbm_pkg::tbm_ctrl_t            next_ctrl;
  tbm_pkg::tbm_mode_t            mode;
  logic [tbm_pkg::DATA_W-1:0]    next_prdata;
  logic                          next_pready;
  logic                          next_pslverr;
  logic                          wr_access;
  logic                          addr_ok;
  logic                          sw_trig;
  logic                          shift_pulse;
  logic                          sq_prev;
  logic                          src_prev;
  logic                          man_prev;
  logic                          sel_src;
  logic                          trig_edge;
  logic                          gate_true;
  logic                          square_fall;
  logic                          run_force_set_n;
  logic                          next_set_n;
  logic                          flop_j_input;
  logic                          flop_k_input;
  logic                          next_run;
  logic                          next_arb_a;
  logic                          next_arb_b;
  logic                          count_decrement_clock;
  logic                          burst_active;
  logic [CNT_W-1:0]              preset;
  logic [CNT_W-1:0]              count;

  // ----------------------------------------------------------------
  // APB register access
  // ----------------------------------------------------------------

  // Writes land only on the completing access edge
  assign wr_access   = psel && penable && pready && pwrite;
  assign sw_trig     = wr_access && paddr == tbm_pkg::TRIG_OFS
                       && pwdata[tbm_pkg::MAN_TRIG_BIT];
  assign shift_pulse = wr_access && paddr == tbm_pkg::SHIFT_OFS
                       && ctrl.count_load_enable;

  always_comb begin
    addr_ok = 1'b0;
    case (paddr)
      tbm_pkg::CTRL_OFS,
      tbm_pkg::TRIG_OFS,
      tbm_pkg::SHIFT_OFS,
      tbm_pkg::STATUS_OFS,
      tbm_pkg::PRESET_OFS: addr_ok = 1'b1;
      default:             addr_ok = 1'b0;
    endcase
  end

  // One wait-free answer: pready rises for the access cycle only
  always_comb begin
    next_pready  = psel && !penable;
    next_pslverr = psel && !penable && !addr_ok;
    next_prdata  = '0;
    next_ctrl    = ctrl;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        tbm_pkg::CTRL_OFS: begin
          next_prdata[tbm_pkg::CTRL_W-1:0] = ctrl;
        end
        tbm_pkg::STATUS_OFS: begin
          next_prdata[tbm_pkg::ST_RUN_BIT]   = run;
          next_prdata[tbm_pkg::ST_INV_BIT]   = flop_inverted_out;
          next_prdata[tbm_pkg::ST_BURST_BIT] = burst_active;
          next_prdata[tbm_pkg::ST_CNT_LSB +: CNT_W] = count;
        end
        tbm_pkg::PRESET_OFS: begin
          next_prdata[CNT_W-1:0] = preset;
        end
        default: begin
          next_prdata = '0;
        end
      endcase
    end
    if (wr_access && paddr == tbm_pkg::CTRL_OFS) begin
      next_ctrl = pwdata[tbm_pkg::CTRL_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl    <= tbm_pkg::CTRL_RESET;
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      ctrl    <= next_ctrl;
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ----------------------------------------------------------------
  // Mode decode and trigger detection
  // ----------------------------------------------------------------

  // Select lines pick the mode; gate_select splits the shared code 2'b10
  always_comb begin
    case ({ctrl.mode_select_b, ctrl.mode_select_a})
      2'b00:   mode = tbm_pkg::MODE_CONT;
      2'b10:   mode = ctrl.gate_select ? tbm_pkg::MODE_EXTGATE : tbm_pkg::MODE_TRIG;
      2'b11:   mode = tbm_pkg::MODE_BURST;
      default: mode = tbm_pkg::MODE_IDLE;
    endcase
  end

  // Trigger source: low is the external input, high the reference
  assign sel_src     = ctrl.trigger_source_sel ? reference_a : external_freq_in;
  // Manual key or remote command counts like a trigger edge
  assign trig_edge   = (sel_src && !src_prev) || (manual_trigger && !man_prev)
                       || sw_trig;
  assign gate_true   = sel_src || manual_trigger;
  assign square_fall = sq_prev && !gen_square_wave;

  // ----------------------------------------------------------------
  // Set strobe and J/K drive
  // ----------------------------------------------------------------

  // Outside continuous mode, starts only from a stopped flop, so a retrigger mid-run is dropped
  always_comb begin
    next_set_n = 1'b1;
    case (mode)
      tbm_pkg::MODE_CONT:    next_set_n = 1'b0;
      tbm_pkg::MODE_TRIG,
      tbm_pkg::MODE_BURST:   next_set_n = !(trig_edge && !run && run_force_set_n);
      tbm_pkg::MODE_EXTGATE: next_set_n = !(gate_true && !run && run_force_set_n);
      tbm_pkg::MODE_IDLE:    next_set_n = 1'b1;
      default:               next_set_n = 1'b1;
    endcase
  end

  // J/K levels seen by the flop on each falling square edge
  always_comb begin
    flop_j_input = 1'b0;
    flop_k_input = 1'b1;
    case (mode)
      tbm_pkg::MODE_CONT: begin
        flop_j_input = 1'b0;
        flop_k_input = 1'b0;
      end
      tbm_pkg::MODE_TRIG: begin
        flop_j_input = 1'b0;
        flop_k_input = 1'b1;
      end
      tbm_pkg::MODE_BURST: begin
        flop_j_input = burst_active;
        flop_k_input = !burst_active;
      end
      tbm_pkg::MODE_EXTGATE: begin
        flop_j_input = gate_true;
        flop_k_input = !gate_true;
      end
      default: begin
        flop_j_input = 1'b0;
        flop_k_input = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Run flop
  // ----------------------------------------------------------------

  // Set overrides the clocked JK step, as a direct set would
  always_comb begin
    next_run = run;
    if (!run_force_set_n) begin
      next_run = 1'b1;
    end else if (square_fall) begin
      case ({flop_j_input, flop_k_input})
        2'b10:   next_run = 1'b1;
        2'b01:   next_run = 1'b0;
        2'b11:   next_run = !run;
        default: next_run = run;
      endcase
    end
  end

  // Counter steps once per finished generator cycle
  assign count_decrement_clock = square_fall && run;

  // Arb clocks pick one of four sources, registered to stay glitch-free
  always_comb begin
    case (ctrl.arb_clk_source_a)
      tbm_pkg::SRC_SQUARE: next_arb_a = gen_square_wave;
      tbm_pkg::SRC_REF:    next_arb_a = reference_a;
      tbm_pkg::SRC_EXT:    next_arb_a = external_freq_in;
      default:             next_arb_a = local_clock;
    endcase
    case (ctrl.arb_clk_source_b)
      tbm_pkg::SRC_SQUARE: next_arb_b = gen_square_wave;
      tbm_pkg::SRC_REF:    next_arb_b = reference_a;
      tbm_pkg::SRC_EXT:    next_arb_b = external_freq_in;
      default:             next_arb_b = local_clock;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_force_set_n   <= 1'b1;
      run               <= 1'b0;
      flop_inverted_out <= 1'b1;
      sq_prev           <= 1'b0;
      src_prev          <= 1'b0;
      man_prev          <= 1'b0;
      arb_clock_a       <= 1'b0;
      arb_clock_b       <= 1'b0;
    end else begin
      run_force_set_n   <= next_set_n;
      run               <= next_run;
      flop_inverted_out <= !next_run;
      sq_prev           <= gen_square_wave;
      src_prev          <= sel_src;
      man_prev          <= manual_trigger;
      arb_clock_a       <= next_arb_a;
      arb_clock_b       <= next_arb_b;
    end
  end

  // ----------------------------------------------------------------
  // Burst counter
  // ----------------------------------------------------------------

  // Preset is copied in while the start strobe is low
  tbm_burst_counter #(
    .CNT_W (CNT_W)
  ) u_burst_counter (
    .pclk                  (pclk),
    .presetn               (presetn),
    .count_shift_clock     (shift_pulse),
    .count_serial_in       (pwdata[tbm_pkg::SERIAL_BIT]),
    .load                  (!run_force_set_n),
    .count_decrement_clock (count_decrement_clock),
    .preset                (preset),
    .count                 (count),
    .burst_active          (burst_active)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_armed_trig;
    mode == tbm_pkg::MODE_TRIG && !run && run_force_set_n;
  endsequence

  // Three samples: the release edge itself still sits in reset
  a_cont_run_high: assert property (
    mode == tbm_pkg::MODE_CONT ##1 mode == tbm_pkg::MODE_CONT
    ##1 mode == tbm_pkg::MODE_CONT |=> run)
    else $error("continuous mode did not hold run high");

  a_strobe_sets_run: assert property (
    !run_force_set_n |=> run && !flop_inverted_out)
    else $error("set strobe did not raise run");

  a_strobe_one_cycle: assert property (
    !run_force_set_n && mode != tbm_pkg::MODE_CONT |=> run_force_set_n)
    else $error("set strobe longer than one cycle");

  a_no_retrigger: assert property (
    run && mode != tbm_pkg::MODE_CONT |=> run_force_set_n)
    else $error("strobe while generator running");

  a_trig_starts: assert property (
    s_armed_trig and sw_trig |=> !run_force_set_n ##1 run)
    else $error("trigger did not start the generator");

  a_source_ignored: assert property (
    s_armed_trig and (!ctrl.trigger_source_sel && !external_freq_in
                      && !manual_trigger && !sw_trig) |=> run_force_set_n)
    else $error("unselected source started the generator");

  a_trig_stops: assert property (
    mode == tbm_pkg::MODE_TRIG && run && run_force_set_n && square_fall |=> !run)
    else $error("triggered run not ended on falling edge");

  a_trig_holds: assert property (
    mode == tbm_pkg::MODE_TRIG && run_force_set_n && !square_fall |=> run == $past(run))
    else $error("triggered run changed off a falling edge");

  a_burst_continues: assert property (
    mode == tbm_pkg::MODE_BURST && burst_active && run_force_set_n && square_fall
    |=> run)
    else $error("burst stopped before count reached zero");

  a_burst_ends: assert property (
    mode == tbm_pkg::MODE_BURST && !burst_active && run_force_set_n && square_fall
    |=> !run)
    else $error("burst did not stop at zero count");

  a_gate_follows: assert property (
    mode == tbm_pkg::MODE_EXTGATE && run_force_set_n && square_fall
    |=> run == $past(gate_true))
    else $error("gate level not followed on falling edge");

  a_arb_select: assert property (
    ctrl.arb_clk_source_a == tbm_pkg::SRC_LOCAL |=> arb_clock_a == $past(local_clock))
    else $error("arb clock a not from local clock");

endmodule

// *** test/tbm_gen_model.sv ***
// Generator loop model that returns the square wave while run is high
module tbm_gen_model (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Loop control
  input  wire logic run,
  input  wire logic slow,
  // Square wave back to the block
  output logic      gen_square_wave
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [3:0] half_cnt;
  logic [3:0] half_len;

  // Slow mode stretches each half period to test a lagging loop
  assign half_len = slow ? 4'h6 : 4'h2;

  // Square parks low while stopped, so a halted loop shows no edges
  always @(posedge pclk or negedge presetn) begin
    if (!presetn || !run) begin
      half_cnt        <= 4'h0;
      gen_square_wave <= 1'b0;
    end else if (half_cnt == half_len - 4'h1) begin
      half_cnt        <= 4'h0;
      gen_square_wave <= ~gen_square_wave;
    end else begin
      half_cnt <= half_cnt + 4'h1;
    end
  end
endmodule

// *** test/test_trigger_burst_mode_control.sv ***
// Self-checking bench for the trigger and burst mode control block
module test_trigger_burst_mode_control;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        pclk, presetn, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, err, slow, prev_sq;
  logic        gen_square_wave, reference_a, external_freq_in, local_clock;
  logic        manual_trigger, run, flop_inverted_out, arb_clock_a, arb_clock_b;
  int          failures, samples_checked, falls_seen;

  tbm_mode_ctrl #(.CNT_W(16)) tbm_mode_ctrl_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .gen_square_wave(gen_square_wave),
    .reference_a(reference_a), .external_freq_in(external_freq_in),
    .local_clock(local_clock), .manual_trigger(manual_trigger), .run(run),
    .flop_inverted_out(flop_inverted_out), .arb_clock_a(arb_clock_a),
    .arb_clock_b(arb_clock_b));

  tbm_gen_model tbm_gen_model_inst (
    .pclk(pclk), .presetn(presetn), .run(run), .slow(slow),
    .gen_square_wave(gen_square_wave));

  // Free-running 250 MHz clock
  always #2 pclk = ~pclk;

  // Count falling square samples seen while running
  always @(posedge pclk) begin
    prev_sq <= gen_square_wave;
    if (prev_sq === 1'b1 && gen_square_wave === 1'b0 && run === 1'b1) begin
      falls_seen <= falls_seen + 1;
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("Counts: %0d checked, %0d failed", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check_bit(input logic exp, input logic act);
    samples_checked++;
    if (act !== exp) begin
      failures++;
      $display("Error at %0t: expected %h got %h", $time, exp, act);
    end
  endtask

  task automatic check_word(input logic [31:0] exp, input logic [31:0] act);
    samples_checked++;
    if (act !== exp) begin
      failures++;
      $display("Error at %0t: expected %h got %h", $time, exp, act);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      failures++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Bounded wait for run to reach a level
  task automatic wait_run(input logic exp, input int bound);
    int n;
    for (n = 0; n < bound; n++) begin
      if (run === exp) break;
      @(posedge pclk);
    end
    if (n == bound) begin
      failures++;
      stop_test();
    end
    check_bit(exp, run);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset_cont();
    wait_run(1'b1, 4);
    apb_xfer(1'b0, tbm_pkg::CTRL_OFS, 32'h0);
    check_word(32'h0, rd);
    apb_xfer(1'b0, tbm_pkg::STATUS_OFS, 32'h0);
    check_bit(1'b1, rd[0]);
    check_bit(1'b0, rd[1]);
    apb_xfer(1'b0, 8'h14, 32'h0);
    check_bit(1'b1, err);
    check_word(32'h0, rd);
    $display("Done: reset and continuous");
  endtask

  task automatic test_triggered();
    int base;
    apb_xfer(1'b1, tbm_pkg::CTRL_OFS, 32'h2);
    wait_run(1'b0, 50);
    check_bit(1'b1, flop_inverted_out);
    base = falls_seen;
    @(posedge pclk);
    external_freq_in <= 1'b1;
    wait_run(1'b1, 6);
    @(posedge pclk);
    external_freq_in <= 1'b0;
    @(posedge pclk);
    external_freq_in <= 1'b1;
    wait_run(1'b0, 50);
    check_word(32'h1, 32'(falls_seen - base));
    repeat (10) @(posedge pclk);
    check_bit(1'b0, run);
    external_freq_in <= 1'b0;
    // Reference edge must not start while the external line is chosen
    @(posedge pclk);
    reference_a <= 1'b1;
    repeat (8) @(posedge pclk);
    check_bit(1'b0, run);
    reference_a <= 1'b0;
    apb_xfer(1'b1, tbm_pkg::CTRL_OFS, 32'hA);
    reference_a <= 1'b1;
    wait_run(1'b1, 6);
    reference_a <= 1'b0;
    wait_run(1'b0, 50);
    // Register trigger takes the same path as a pin edge
    base = falls_seen;
    apb_xfer(1'b1, tbm_pkg::TRIG_OFS, 32'h1);
    wait_run(1'b1, 6);
    wait_run(1'b0, 50);
    check_word(32'h1, 32'(falls_seen - base));
    $display("Done: triggered");
  endtask

  task automatic test_burst();
    logic [15:0] cnt;
    int          i;
    int          base;
    cnt = 16'h0003;
    apb_xfer(1'b1, tbm_pkg::CTRL_OFS, 32'h1);
    apb_xfer(1'b1, tbm_pkg::SHIFT_OFS, 32'h1);
    apb_xfer(1'b0, tbm_pkg::PRESET_OFS, 32'h0);
    check_word(32'h0, rd);
    apb_xfer(1'b1, tbm_pkg::CTRL_OFS, 32'h101);
    for (i = 15; i >= 0; i--) begin
      apb_xfer(1'b1, tbm_pkg::SHIFT_OFS, {31'h0, cnt[i]});
    end
    apb_xfer(1'b0, tbm_pkg::PRESET_OFS, 32'h0);
    check_word(32'h3, rd);
    apb_xfer(1'b1, tbm_pkg::CTRL_OFS, 32'h3);
    slow <= 1'b1;
    base = falls_seen;
    apb_xfer(1'b1, tbm_pkg::TRIG_OFS, 32'h1);
    wait_run(1'b1, 6);
    wait_run(1'b0, 200);
    // One cycle per count, plus the cycle whose fall sees zero
    check_word(32'h4, 32'(falls_seen - base));
    apb_xfer(1'b0, tbm_pkg::STATUS_OFS, 32'h0);
    check_word(32'h2, rd);
    slow <= 1'b0;
    $display("Done: burst");
  endtask

  task automatic test_ext_gate();
    apb_xfer(1'b1, tbm_pkg::CTRL_OFS, 32'h6);
    manual_trigger <= 1'b1;
    wait_run(1'b1, 6);
    repeat (40) @(posedge pclk);
    check_bit(1'b1, run);
    manual_trigger <= 1'b0;
    wait_run(1'b0, 40);
    check_bit(1'b1, flop_inverted_out);
    $display("Done: external gate");
  endtask

  task automatic test_arb_clocks();
    int   k;
    int   v;
    logic e;
    // Idle mode parks the square low so every source is static
    apb_xfer(1'b1, tbm_pkg::CTRL_OFS, 32'h1);
    wait_run(1'b0, 50);
    for (k = 0; k < 4; k++) begin
      apb_xfer(1'b1, tbm_pkg::CTRL_OFS, 32'((3 - k) * 64 + k * 16 + 1));
      for (v = 0; v < 2; v++) begin
        reference_a      <= v[0];
        external_freq_in <= ~v[0];
        local_clock      <= v[0];
        repeat (3) @(posedge pclk);
        e = (k == 0) ? 1'b0 : (k == 2) ? ~v[0] : v[0];
        check_bit(e, arb_clock_a);
        e = (k == 3) ? 1'b0 : (k == 1) ? ~v[0] : v[0];
        check_bit(e, arb_clock_b);
      end
    end
    check_bit(1'b0, run);
    $display("Done: arb clocks");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    reference_a = 1'b0;
    external_freq_in = 1'b0;
    local_clock = 1'b0;
    manual_trigger = 1'b0;
    slow = 1'b0;
    prev_sq = 1'b0;
    falls_seen = 0;
    failures = 0;
    samples_checked = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    test_reset_cont();
    test_triggered();
    test_burst();
    test_ext_gate();
    test_arb_clocks();
    stop_test();
  end
endmodule
